// *** hdl/stsr_pkg.sv ***
// Constants shared by the timer and processor-state register bank.
// Assumes a Wishbone classic slave port with 32-bit data and byte addresses.
package stsr_pkg;
  // Byte offsets of the registers
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_MATCH = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_INFO = 8'h10;
  // Processor-state bit positions
  localparam int B_CU3 = 31;
  localparam int B_CU2 = 30;
  localparam int B_CU1 = 29;
  localparam int B_SCR = 28;
  localparam int B_DSP = 24;
  localparam int B_BEV = 22;
  localparam int B_SRF = 20;
  localparam int B_NMF = 19;
  localparam int B_IM9 = 18;
  localparam int B_IMLO = 10;
  localparam int B_IMHI = 16;
  localparam int B_SWLO = 8;
  localparam int B_UM = 4;
  localparam int B_ERL = 2;
  localparam int B_EXL = 1;
  localparam int B_IE = 0;
  // Plainly writable state bits: scratch, dsp, bev, masks, um, erl, exl, ie
  localparam logic [31:0] STATE_WMASK = 32'h1145_FF17;
  // Reset value: bootstrap vectors and error level set
  localparam logic [31:0] STATE_RST = 32'h0040_0004;
  // Control register bit positions
  localparam int C_HALT = 0;
  localparam int C_TICKDBG = 1;
  localparam int C_EIC = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Timer reset values and a zero word
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] MATCH_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_KERNEL,
    MODE_USER,
    MODE_DEBUG
  } stsr_mode_e;

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] stsr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : stsr_merge
endpackage : stsr_pkg

// *** hdl/stsr_timer.sv ***
// Interval counter, match register and timer interrupt flag.
// Assumes write strobes are single-cycle pulses from the register bank.
`timescale 1ns/1ps
`default_nettype none
module stsr_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic halt_i,
  input wire logic hold_i,
  input wire logic wr_count_i,
  input wire logic wr_match_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] count_o,
  output logic [31:0] match_o,
  output logic irq_o
);
  import stsr_pkg::*;

  logic phase_r;

  // Divide by two; runs every clock, no pipeline input involved
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Counter: software write wins, else step on odd phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= COUNT_RST;
    end else if (wr_count_i) begin
      count_o <= stsr_merge(count_o, wdata_i, sel_i);
    end else if (phase_r && !halt_i && !hold_i) begin
      count_o <= count_o + 32'h0000_0001;
    end
  end

  // Match register changes only on software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_o <= MATCH_RST;
    end else if (wr_match_i) begin
      match_o <= stsr_merge(match_o, wdata_i, sel_i);
    end
  end

  // Sticky interrupt; a match-register write clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (wr_match_i) begin
      irq_o <= 1'b0;
    end else if (count_o == match_o) begin
      irq_o <= 1'b1;
    end
  end
endmodule : stsr_timer
`default_nettype wire

// *** hdl/stsr_regs.sv ***
// Timer and processor-state register bank with a Wishbone classic slave.
// Assumes the exception sequencer pulses the event inputs for one clock,
// and that the pipeline presents coprocessor and dsp checks as pulses.
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module stsr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core state and events
  input wire logic debug_mode_flag_i,
  input wire logic copro_two_attached_i,
  input wire logic soft_reset_i,
  input wire logic nmi_entry_i,
  input wire logic error_exc_i,
  input wire logic exception_i,
  // Interrupt sources
  input wire logic [7:0] hw_irq_i,
  input wire logic [1:0] sw_irq_i,
  input wire logic [7:0] eic_req_level_i,
  // Instruction checks
  input wire logic cop_req_i,
  input wire logic [1:0] cop_num_i,
  input wire logic dsp_req_i,
  // Results
  output logic timer_irq_out_o,
  output logic irq_take_o,
  output stsr_pkg::stsr_mode_e mode_o,
  output logic boot_vector_select_o,
  output logic cop_unusable_o,
  output logic dsp_disabled_o
);
  import stsr_pkg::*;

  logic [31:0] state_r;
  logic [31:0] state_nxt;
  logic [2:0] ctrl_r;
  logic [31:0] count_w;
  logic [31:0] match_w;
  logic timer_irq_w;
  logic req_w;
  logic wr_w;
  logic wr_count_w;
  logic wr_match_w;
  logic wr_state_w;
  logic wr_ctrl_w;
  logic [31:0] state_rd_w;
  logic [31:0] wmerge_w;
  logic [7:0] hw_mask_w;
  logic [1:0] sw_mask_w;
  logic levels_ok_w;
  logic pend_w;
  logic user_w;
  logic hold_w;
  logic [31:0] rdata_nxt;
  stsr_mode_e mode_nxt;

  // Bus request decode; a request is answered one clock later
  assign req_w = cyc_i && stb_i && !ack_o;
  assign wr_w = req_w && we_i;
  assign wr_count_w = wr_w && (adr_i == OFF_COUNT);
  assign wr_match_w = wr_w && (adr_i == OFF_MATCH);
  assign wr_state_w = wr_w && (adr_i == OFF_STATE);
  assign wr_ctrl_w = wr_w && (adr_i == OFF_CTRL);

  // Counter holds in debug mode unless told to keep ticking
  assign hold_w = debug_mode_flag_i && !ctrl_r[C_TICKDBG];

  // Interval timer
  stsr_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .halt_i(ctrl_r[C_HALT]),
    .hold_i(hold_w),
    .wr_count_i(wr_count_w),
    .wr_match_i(wr_match_w),
    .sel_i(sel_i),
    .wdata_i(dat_i),
    .count_o(count_w),
    .match_o(match_w),
    .irq_o(timer_irq_w)
  );

  // Read view of the processor state; unusable and reserved bits forced zero
  always_comb begin
    state_rd_w = state_r & (STATE_WMASK | 32'h4018_0000);
    state_rd_w[B_CU3] = 1'b0;
    state_rd_w[B_CU1] = 1'b0;
    state_rd_w[27:25] = 3'h0;
    state_rd_w[23] = 1'b0;
    state_rd_w[21] = 1'b0;
    state_rd_w[17] = 1'b0;
    state_rd_w[7:5] = 3'h0;
    state_rd_w[3] = 1'b0;
    if (!copro_two_attached_i) begin
      state_rd_w[B_CU2] = 1'b0;
    end
  end

  // Byte-lane merged write data for the state register
  assign wmerge_w = stsr_merge(state_rd_w, dat_i, sel_i);

  // Next processor state: software write first, hardware events on top
  always_comb begin
    state_nxt = state_r;
    if (wr_state_w) begin
      // Plain bits: scratch, dsp gate, bev, masks, um, erl, exl, ie
      state_nxt = (state_r & ~STATE_WMASK) | (wmerge_w & STATE_WMASK);
      // Coprocessor two bit only when one is attached
      if (copro_two_attached_i) begin
        state_nxt[B_CU2] = wmerge_w[B_CU2];
      end
      // Entry-cause flags may only be cleared
      state_nxt[B_SRF] = state_r[B_SRF] & wmerge_w[B_SRF];
      state_nxt[B_NMF] = state_r[B_NMF] & wmerge_w[B_NMF];
    end
    // Ordinary exceptions raise exception level
    if (exception_i) begin
      state_nxt[B_EXL] = 1'b1;
    end
    // Memory error exceptions raise error level
    if (error_exc_i) begin
      state_nxt[B_ERL] = 1'b1;
    end
    // Non-maskable entry through the reset vector
    if (nmi_entry_i) begin
      state_nxt[B_ERL] = 1'b1;
      state_nxt[B_BEV] = 1'b1;
      state_nxt[B_NMF] = 1'b1;
      state_nxt[B_SRF] = 1'b0;
    end
    // Soft reset entry through the reset vector
    if (soft_reset_i) begin
      state_nxt[B_ERL] = 1'b1;
      state_nxt[B_BEV] = 1'b1;
      state_nxt[B_SRF] = 1'b1;
      state_nxt[B_NMF] = 1'b0;
      state_nxt[B_CU2] = 1'b0;
      state_nxt[B_DSP] = 1'b0;
      state_nxt[B_IM9] = 1'b0;
      state_nxt[B_IMHI] = 1'b0;
    end
    // Bits that never hold a value
    state_nxt[B_CU3] = 1'b0;
    state_nxt[B_CU1] = 1'b0;
    state_nxt[27:25] = 3'h0;
    state_nxt[23] = 1'b0;
    state_nxt[21] = 1'b0;
    state_nxt[17] = 1'b0;
    state_nxt[7:5] = 3'h0;
    state_nxt[3] = 1'b0;
  end

  // Processor state register; hard reset clears both entry flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Control register: count halt, tick in debug, external controller mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl_w && sel_i[0]) begin
      ctrl_r <= dat_i[2:0];
    end
  end

  // Masks and threshold share the same bits
  assign hw_mask_w = {state_r[B_IM9], state_r[B_IMHI:B_IMLO]};
  assign sw_mask_w = state_r[B_SWLO+1:B_SWLO];

  // Global gating by enable, levels and debug
  assign levels_ok_w = state_r[B_IE] && !state_r[B_EXL] && !state_r[B_ERL]
                       && !debug_mode_flag_i;

  // Pending request per interrupt scheme
  always_comb begin
    if (ctrl_r[C_EIC]) begin
      pend_w = eic_req_level_i > hw_mask_w;
    end else begin
      pend_w = |(hw_irq_i & hw_mask_w) || |(sw_irq_i & sw_mask_w);
    end
  end

  // Interrupt take signal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_take_o <= 1'b0;
    end else begin
      irq_take_o <= levels_ok_w && pend_w;
    end
  end

  // Operating mode decode
  assign user_w = state_r[B_UM] && !state_r[B_EXL] && !state_r[B_ERL];
  always_comb begin
    if (debug_mode_flag_i) begin
      mode_nxt = MODE_DEBUG;
    end else if (user_w) begin
      mode_nxt = MODE_USER;
    end else begin
      mode_nxt = MODE_KERNEL;
    end
  end

  // Registered mode output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= MODE_KERNEL;
    end else begin
      mode_o <= mode_nxt;
    end
  end

  // Coprocessor usability check; zero is usable in kernel and debug only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cop_unusable_o <= 1'b0;
    end else if (!cop_req_i) begin
      cop_unusable_o <= 1'b0;
    end else begin
      case (cop_num_i)
        2'h0: cop_unusable_o <= (mode_nxt == MODE_USER);
        2'h2: cop_unusable_o <= !state_rd_w[B_CU2];
        default: cop_unusable_o <= 1'b1;
      endcase
    end
  end

  // Signal-processing instruction gate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsp_disabled_o <= 1'b0;
    end else begin
      dsp_disabled_o <= dsp_req_i && !state_r[B_DSP];
    end
  end

  // Registered copies of timer interrupt and vector select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_irq_out_o <= 1'b0;
      boot_vector_select_o <= 1'b1;
    end else begin
      timer_irq_out_o <= timer_irq_w;
      boot_vector_select_o <= state_nxt[B_BEV];
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    case (adr_i)
      OFF_COUNT: rdata_nxt = count_w;
      OFF_MATCH: rdata_nxt = match_w;
      OFF_STATE: rdata_nxt = state_rd_w;
      OFF_CTRL: rdata_nxt = {29'h0000_0000, ctrl_r};
      OFF_INFO: rdata_nxt = {27'h000_0000, timer_irq_w, irq_take_o, pend_w, mode_o};
      default: rdata_nxt = ZERO32;
    endcase
  end

  // Acknowledge and read data, one clock after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= ZERO32;
    end else begin
      ack_o <= req_w;
      if (req_w && !we_i) begin
        dat_o <= rdata_nxt;
      end
    end
  end
endmodule : stsr_regs
`default_nettype wire

// *** test/stsr_regs_chk_sva.sv ***
// Port checker for the timer and processor-state bank.
// Assumes a classic Wishbone master that holds its request until ack.
`timescale 1ns/1ps
`default_nettype none
module stsr_regs_chk
  import stsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic ack_o,
  input wire logic debug_mode_flag_i,
  input wire logic cop_req_i,
  input wire logic [1:0] cop_num_i,
  input wire logic dsp_req_i,
  input wire logic timer_irq_out_o,
  input wire logic irq_take_o,
  input wire logic [1:0] mode_o,
  input wire logic boot_vector_select_o,
  input wire logic cop_unusable_o,
  input wire logic dsp_disabled_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Match write taken at this edge
  logic wr_m;
  assign wr_m = cyc_i && stb_i && we_i && !ack_o && adr_i == OFF_MATCH;
  // Timer flag seen with no match write for two edges
  sequence s_quiet;
    !wr_m ##1 (timer_irq_out_o && !wr_m);
  endsequence
  sequence s_dbg2;
    debug_mode_flag_i ##1 debug_mode_flag_i;
  endsequence
  // Bus handshake, reset values, timer flag, gating and access checks
  chk_ack_one: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  chk_ack_drop: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_reset_state: assert property ($fell(rst_i) |-> boot_vector_select_o && mode_o == MODE_KERNEL && !timer_irq_out_o)
    else $error("outputs wrong after reset");
  chk_irq_hold: assert property (s_quiet |=> timer_irq_out_o)
    else $error("timer flag dropped without match write");
  chk_irq_clear: assert property (wr_m |-> ##2 !timer_irq_out_o)
    else $error("timer flag kept after match write");
  chk_take_debug: assert property (irq_take_o |-> !$past(debug_mode_flag_i))
    else $error("interrupt taken in debug mode");
  chk_mode_debug: assert property (s_dbg2 |-> mode_o == MODE_DEBUG)
    else $error("debug mode not shown");
  chk_cop_odd: assert property (cop_req_i && cop_num_i[0] |=> cop_unusable_o)
    else $error("absent coprocessor reached");
  chk_dsp_cause: assert property (dsp_disabled_o |-> $past(dsp_req_i))
    else $error("dsp fault without request");
endmodule : stsr_regs_chk
`default_nettype wire

// *** test/stsr_cpu_model.sv ***
// Pipeline-side bus master issuing privileged register moves.
// Assumes a classic Wishbone slave that answers with ack.
`timescale 1ns/1ps
`default_nettype none
module stsr_cpu_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h0;
  end
  // One classic cycle; released address and data lines show inverted stale values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : stsr_cpu_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the timer and processor-state bank.
// Assumes the bus model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stsr_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] EVB [4] = '{32'h0010_0000, 32'h0008_0000, 32'h0000_0004, 32'h0000_0002};
  localparam logic [31:0] MST [5] = '{32'h0000_0411, 32'h0000_0413, 32'h0000_0410, 32'h0000_0015, 32'h0000_0411};
  localparam stsr_mode_e MEX [5] = '{MODE_USER, MODE_KERNEL, MODE_USER, MODE_KERNEL, MODE_DEBUG};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o, timer_irq_out_o, irq_take_o, cop_unusable_o, dsp_disabled_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, r, c;
  logic debug_mode_flag_i = 1'b0;
  logic att = 1'b0;
  logic creq = 1'b0;
  logic dreq = 1'b0;
  logic [1:0] cnum = 2'h0;
  logic [3:0] evp = 4'h0;
  logic [7:0] external_irq_ctrl_mode = 8'h00;
  logic [7:0] hwi = 8'h01;
  logic [1:0] swi = 2'h0;
  logic bvs;
  stsr_mode_e mode_o;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 72878;
  int t;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  stsr_regs i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .debug_mode_flag_i, .copro_two_attached_i(att), .soft_reset_i(evp[0]), .nmi_entry_i(evp[1]),
    .error_exc_i(evp[2]), .exception_i(evp[3]), .hw_irq_i(hwi), .sw_irq_i(swi), .eic_req_level_i(external_irq_ctrl_mode),
    .cop_req_i(creq), .cop_num_i(cnum), .dsp_req_i(dreq), .timer_irq_out_o, .irq_take_o, .mode_o,
    .boot_vector_select_o(bvs), .cop_unusable_o, .dsp_disabled_o);
  stsr_cpu_model i_cpu (.clk_i, .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i),
    .sel_o(sel_i), .dat_o(dat_i));
  // Clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cpu.xfer(1'b1, a, d);
  endtask : wr
  // Note the expected word and mask, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e & m);
    mq.push_back(m);
    i_cpu.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic pulse_ev(input logic [3:0] v);
    @(posedge clk_i);
    evp <= v;
    @(posedge clk_i);
    evp <= 4'h0;
  endtask : pulse_ev
  // Read data monitor against the oldest note
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      chk(dat_o & mq.pop_front(), eq.pop_front());
    end
  end
  // Watchdog
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_STATE, 32'h0040_0004, ALL);
    chk(bvs, 1'b1);
    rd(8'h20, 32'h0, ALL);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_STATE, 32'h0);
      pulse_ev(4'h1 << k);
      rd(OFF_STATE, ALL, EVB[k]);
      chk(bvs, k < 2);
    end
    wr(OFF_STATE, 32'h0);
    rd(OFF_STATE, 32'h0, ALL);
    wr(OFF_STATE, ALL);
    rd(OFF_STATE, 32'h1145_FF17, ALL);
    att <= 1'b1;
    r = $random(seed);
    wr(OFF_STATE, r);
    rd(OFF_STATE, r & 32'h5145_FF17, ALL);
    // Counter runs, halts, and follows the debug tick choice
    for (int k = 0; k < 4; k++) begin
      debug_mode_flag_i <= k[1];
      wr(OFF_CTRL, {30'h0, k == 3, k == 1});
      c = 32'hFFFF_FFF0 + k;
      wr(OFF_COUNT, c);
      wr(OFF_MATCH, c + 32'h14);
      @(posedge clk_i);
      #1 chk(timer_irq_out_o, 1'b0);
      t = 0;
      while (timer_irq_out_o !== 1'b1 && t < 80) begin
        @(negedge clk_i);
        t++;
      end
      chk(t >= 34 && t <= 44, k[0] == k[1]);
      if (k == 1) begin
        rd(OFF_COUNT, c, ALL);
      end
      rd(OFF_MATCH, c + 32'h14, ALL);
    end
    // Mode decode and interrupt acceptance
    wr(OFF_CTRL, 32'h0);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      debug_mode_flag_i <= k == 4;
      wr(OFF_STATE, MST[k]);
      repeat (3) @(posedge clk_i);
      #1 chk(mode_o, MEX[k]);
      chk(irq_take_o, k == 0);
    end
    // Software request through its own mask, hardware requests quiet
    @(posedge clk_i);
    debug_mode_flag_i <= 1'b0;
    hwi <= 8'h00;
    swi <= 2'h1;
    wr(OFF_STATE, 32'h0000_0101);
    repeat (3) @(posedge clk_i);
    #1 chk(irq_take_o, 1'b1);
    // Threshold mode; software masks stay set but must not matter
    wr(OFF_CTRL, 32'h4);
    wr(OFF_STATE, 32'h0000_1701);
    for (int k = 4; k < 7; k++) begin
      @(posedge clk_i);
      external_irq_ctrl_mode <= k[7:0];
      repeat (3) @(posedge clk_i);
      #1 chk(irq_take_o, k == 6);
    end
    // Coprocessor and signal-processing access checks
    for (int s = 0; s < 2; s++) begin
      wr(OFF_STATE, s ? 32'h4100_0010 : 32'h0);
      for (int n = 0; n < 4; n++) begin
        @(posedge clk_i);
        cnum <= n[1:0];
        creq <= 1'b1;
        dreq <= 1'b1;
        @(posedge clk_i);
        creq <= 1'b0;
        dreq <= 1'b0;
        #1 chk(cop_unusable_o, n[0] || (n == 2 && s == 0) || (n == 0 && s == 1));
        chk(dsp_disabled_o, s == 0);
      end
    end
    give_verdict();
  end
endmodule : tb_top
bind stsr_regs stsr_regs_chk i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .ack_o, .debug_mode_flag_i,
  .cop_req_i, .cop_num_i, .dsp_req_i, .timer_irq_out_o, .irq_take_o, .mode_o, .boot_vector_select_o,
  .cop_unusable_o, .dsp_disabled_o);
`default_nettype wire
